//--- core/t8sc_regs.vh
`ifndef T8SC_REGS_VH
`define T8SC_REGS_VH
// register byte offsets on the apb bus
`define T8SC_CTRL_OFF 8'h00
`define T8SC_CLK_OFF 8'h04
`define T8SC_CNT_OFF 8'h08
`define T8SC_CMP_OFF 8'h0c
`define T8SC_FLAG_OFF 8'h10
`define T8SC_MASK_OFF 8'h14
`define T8SC_STAT_OFF 8'h18
// control register fields
`define T8SC_WAVE_LSB 0
`define T8SC_ACT_LSB 4
`define T8SC_FORCE_BIT 7
// clock register fields
`define T8SC_CS_LSB 0
`define T8SC_ASYNC_BIT 3
// flag and mask bit positions
`define T8SC_OVF_BIT 0
`define T8SC_MATCH_BIT 1
// status register bit positions
`define T8SC_ST_WAVE_BIT 0
`define T8SC_ST_BOT_BIT 1
`define T8SC_ST_MAX_BIT 2
`define T8SC_ST_DOWN_BIT 3
// waveform modes
`define T8SC_MODE_NORMAL 2'h0
`define T8SC_MODE_PHASE 2'h1
`define T8SC_MODE_CTC 2'h2
`define T8SC_MODE_FAST 2'h3
// output actions
`define T8SC_ACT_NONE 2'h0
`define T8SC_ACT_TOGGLE 2'h1
`define T8SC_ACT_CLEAR 2'h2
`define T8SC_ACT_SET 2'h3
// counter extremes
`define T8SC_BOTTOM 8'h00
`define T8SC_MAX 8'hff
// reset values
`define T8SC_RST_BYTE 8'h00
`define T8SC_RST_WORD 32'h0000_0000
`endif

//--- core/t8sc_timer.v
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "t8sc_regs.vh"

module t8sc_timer (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  input wire crystal_in,
  output reg crystal_out,
  input wire overflow_ack_in,
  input wire match_ack_in,
  output reg overflow_irq_out,
  output reg match_irq_out,
  output reg waveform_out
);

  //////////////////////////////////////////////////////////////////////
  // state
  reg [1:0] waveform_mode_bits; // counting mode
  reg [1:0] output_action_bits; // action on match
  reg [2:0] clock_source_select; // zero means stopped
  reg async_clock_select; // crystal as base clock
  reg [7:0] counter_value; // the counter
  reg [7:0] compare_active; // what the comparator sees
  reg [7:0] compare_buffer; // what the cpu sees
  reg overflow_flag; // sticky overflow
  reg match_flag; // sticky match
  reg overflow_irq_enable; // mask bit
  reg match_irq_enable; // mask bit
  reg count_down; // phase correct direction
  reg match_block; // set by counter write
  reg [2:0] xtal_sync; // crystal pin synchroniser
  reg xtal_last; // last agreed crystal level
  reg [9:0] prescale; // divider of the base clock

  //////////////////////////////////////////////////////////////////////
  // decode helpers
  // pwm modes share buffering and force rules, used in several places
  function is_pwm;
    input [1:0] mode;
    begin
      is_pwm = (mode == `T8SC_MODE_PHASE) || (mode == `T8SC_MODE_FAST);
    end
  endfunction

  // new output state for a non-pwm match action
  function apply_action;
    input [1:0] act;
    input cur;
    begin
      case (act)
        `T8SC_ACT_TOGGLE: apply_action = ~cur;
        `T8SC_ACT_CLEAR: apply_action = 1'b0;
        `T8SC_ACT_SET: apply_action = 1'b1;
        default: apply_action = cur;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // bus decode
  wire setup_ph = psel_in && !penable_in;
  wire access_ok = psel_in && penable_in && pready_out;
  wire wr_en = access_ok && pwrite_in;
  wire wr_ctrl = wr_en && (paddr_in == `T8SC_CTRL_OFF);
  wire wr_clk = wr_en && (paddr_in == `T8SC_CLK_OFF);
  wire wr_cnt = wr_en && (paddr_in == `T8SC_CNT_OFF);
  wire wr_cmp = wr_en && (paddr_in == `T8SC_CMP_OFF);
  wire wr_flag = wr_en && (paddr_in == `T8SC_FLAG_OFF);
  wire wr_mask = wr_en && (paddr_in == `T8SC_MASK_OFF);
  wire [7:0] wbyte = pwdata_in[7:0];
  wire pwm_mode = is_pwm(waveform_mode_bits);

  //////////////////////////////////////////////////////////////////////
  // timer tick
  // crystal agreed edge: only stages two and three are examined
  wire xtal_agree = (xtal_sync[1] == xtal_sync[2]);
  wire xtal_rise = xtal_agree && xtal_sync[2] && !xtal_last;
  // base clock is every core edge or each crystal rising edge
  wire base_tick = async_clock_select ? xtal_rise : 1'b1;
  reg tap; // prescaler tap reached
  always @* begin
    case (clock_source_select)
      3'h1: tap = 1'b1;
      3'h2: tap = (prescale[2:0] == 3'h7);
      3'h3: tap = (prescale[4:0] == 5'h1f);
      3'h4: tap = (prescale[5:0] == 6'h3f);
      3'h5: tap = (prescale[6:0] == 7'h7f);
      3'h6: tap = (prescale[7:0] == 8'hff);
      3'h7: tap = (prescale == 10'h3ff);
      default: tap = 1'b0;
    endcase
  end
  wire timer_tick = base_tick && tap;

  // crystal synchroniser and agreed level
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      xtal_sync <= 3'h0;
      xtal_last <= 1'b0;
      crystal_out <= 1'b1;
    end else begin
      xtal_sync <= {xtal_sync[1:0], crystal_in};
      // level only counts as changed once two stages agree
      if (xtal_agree) begin
        xtal_last <= xtal_sync[2];
      end
      // inverting drive back to the crystal
      crystal_out <= ~xtal_sync[2];
    end
  end

  // prescaler runs on base ticks; cleared while stopped
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      prescale <= 10'h000;
    end else if (clock_source_select == 3'h0) begin
      prescale <= 10'h000;
    end else if (base_tick) begin
      prescale <= prescale + 10'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // compare and extremes
  wire at_bottom = (counter_value == `T8SC_BOTTOM);
  wire at_max = (counter_value == `T8SC_MAX);
  wire equal = (counter_value == compare_active);
  // a match only counts on a tick that is not blocked
  wire real_match = timer_tick && equal && !match_block;
  // top is compare in ctc, max in the others
  wire at_top = (waveform_mode_bits == `T8SC_MODE_CTC) ? equal : at_max;
  wire force_hit = wr_ctrl && wbyte[`T8SC_FORCE_BIT] && !is_pwm(wbyte[1:0]);

  //////////////////////////////////////////////////////////////////////
  // counter next value
  reg [7:0] next_counter; // counter after this edge
  reg next_down; // direction after this edge
  reg ovf_event; // overflow seen this tick
  always @* begin
    next_counter = counter_value;
    next_down = count_down;
    ovf_event = 1'b0;
    if (timer_tick) begin
      case (waveform_mode_bits)
        `T8SC_MODE_CTC: begin
          // clear at top, else count up and wrap past max
          if (real_match) begin
            next_counter = `T8SC_BOTTOM;
          end else begin
            next_counter = counter_value + 8'h01;
            ovf_event = at_max;
          end
        end
        `T8SC_MODE_PHASE: begin
          // dual slope, turn at max and at bottom
          if (count_down) begin
            next_counter = counter_value - 8'h01;
            if (counter_value == 8'h01) begin
              next_down = 1'b0;
              ovf_event = 1'b1;
            end
          end else if (at_max) begin
            next_counter = counter_value - 8'h01;
            next_down = 1'b1;
          end else begin
            next_counter = counter_value + 8'h01;
          end
        end
        default: begin
          // normal and fast pwm: up only, wrap max to bottom
          next_counter = counter_value + 8'h01;
          ovf_event = at_max;
          next_down = 1'b0;
        end
      endcase
    end
    // cpu write wins over clear and count
    if (wr_cnt) begin
      next_counter = wbyte;
    end
  end

  // counter, direction and block
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      counter_value <= `T8SC_RST_BYTE;
      count_down <= 1'b0;
      match_block <= 1'b0;
    end else begin
      counter_value <= next_counter;
      count_down <= next_down;
      // block holds until the next tick, even when stopped
      if (wr_cnt) begin
        match_block <= 1'b1;
      end else if (timer_tick) begin
        match_block <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // compare registers
  // buffer loads on the tick at max, for both fast pwm and phase correct
  wire load_point = timer_tick &&
    (((waveform_mode_bits == `T8SC_MODE_FAST) && at_max) ||
     ((waveform_mode_bits == `T8SC_MODE_PHASE) && at_max));
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      compare_active <= `T8SC_RST_BYTE;
      compare_buffer <= `T8SC_RST_BYTE;
    end else begin
      if (wr_cmp) begin
        compare_buffer <= wbyte;
      end
      // unbuffered modes write straight through
      if (wr_cmp && !pwm_mode) begin
        compare_active <= wbyte;
      end else if (pwm_mode && load_point) begin
        compare_active <= compare_buffer;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // waveform generator
  reg next_wave; // output state after this edge
  always @* begin
    next_wave = waveform_out;
    case (waveform_mode_bits)
      `T8SC_MODE_FAST: begin
        // match sets or clears, bottom restores
        if (real_match && output_action_bits[1]) begin
          next_wave = output_action_bits[0];
        end
        if (timer_tick && at_max && output_action_bits[1]) begin
          next_wave = ~output_action_bits[0];
        end
      end
      `T8SC_MODE_PHASE: begin
        // clear on up match, set on down match when non-inverted
        if (real_match && output_action_bits[1]) begin
          next_wave = output_action_bits[0] ^ count_down;
        end
      end
      default: begin
        if (real_match) begin
          next_wave = apply_action(output_action_bits, waveform_out);
        end
      end
    endcase
    // forced match uses the action bits being written
    if (force_hit) begin
      next_wave = apply_action(wbyte[5:4], waveform_out);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // control registers
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      waveform_mode_bits <= `T8SC_MODE_NORMAL;
      output_action_bits <= `T8SC_ACT_NONE;
      clock_source_select <= 3'h0;
      async_clock_select <= 1'b0;
      overflow_irq_enable <= 1'b0;
      match_irq_enable <= 1'b0;
      waveform_out <= 1'b0;
    end else begin
      waveform_out <= next_wave;
      if (wr_ctrl) begin
        waveform_mode_bits <= wbyte[`T8SC_WAVE_LSB+1:`T8SC_WAVE_LSB];
        output_action_bits <= wbyte[`T8SC_ACT_LSB+1:`T8SC_ACT_LSB];
      end
      if (wr_clk) begin
        clock_source_select <= wbyte[`T8SC_CS_LSB+2:`T8SC_CS_LSB];
        async_clock_select <= wbyte[`T8SC_ASYNC_BIT];
      end
      if (wr_mask) begin
        overflow_irq_enable <= wbyte[`T8SC_OVF_BIT];
        match_irq_enable <= wbyte[`T8SC_MATCH_BIT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // flags and interrupt requests
  // a set in the same edge as a clear wins, so no event is lost
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      overflow_flag <= 1'b0;
      match_flag <= 1'b0;
      overflow_irq_out <= 1'b0;
      match_irq_out <= 1'b0;
    end else begin
      if (ovf_event && !wr_cnt) begin
        overflow_flag <= 1'b1;
      end else if (overflow_ack_in || (wr_flag && wbyte[`T8SC_OVF_BIT])) begin
        overflow_flag <= 1'b0;
      end
      // forced matches never reach this flag
      if (real_match) begin
        match_flag <= 1'b1;
      end else if (match_ack_in || (wr_flag && wbyte[`T8SC_MATCH_BIT])) begin
        match_flag <= 1'b0;
      end
      // requests follow the gated flags one edge later
      overflow_irq_out <= overflow_flag && overflow_irq_enable;
      match_irq_out <= match_flag && match_irq_enable;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // apb slave
  // answer is prepared in setup, so access always ends in one cycle
  reg [31:0] rd_word; // read mux
  reg rd_err; // unmapped address
  always @* begin
    rd_word = `T8SC_RST_WORD;
    rd_err = 1'b0;
    if (paddr_in == `T8SC_CTRL_OFF) begin
      // force strobe always reads zero
      rd_word[7:0] = {2'h0, output_action_bits, 2'h0, waveform_mode_bits};
    end else if (paddr_in == `T8SC_CLK_OFF) begin
      rd_word[3:0] = {async_clock_select, clock_source_select};
    end else if (paddr_in == `T8SC_CNT_OFF) begin
      rd_word[7:0] = counter_value;
    end else if (paddr_in == `T8SC_CMP_OFF) begin
      rd_word[7:0] = compare_buffer;
    end else if (paddr_in == `T8SC_FLAG_OFF) begin
      rd_word[1:0] = {match_flag, overflow_flag};
    end else if (paddr_in == `T8SC_MASK_OFF) begin
      rd_word[1:0] = {match_irq_enable, overflow_irq_enable};
    end else if (paddr_in == `T8SC_STAT_OFF) begin
      rd_word[3:0] = {count_down, at_max, at_bottom, waveform_out};
    end else begin
      rd_err = 1'b1;
    end
  end

  // ready, data and error registered at the setup edge
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
      prdata_out <= `T8SC_RST_WORD;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= setup_ph;
      if (setup_ph) begin
        prdata_out <= pwrite_in ? `T8SC_RST_WORD : rd_word;
        pslverr_out <= rd_err;
      end else begin
        pslverr_out <= 1'b0;
      end
    end
  end

endmodule

//--- verif/t8sc_props.sv
`timescale 1ns/1ps
// port-level timing checks for the timer, bound into every instance
module t8sc_props (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  input wire crystal_in,
  input wire crystal_out,
  input wire overflow_ack_in,
  input wire match_ack_in,
  input wire overflow_irq_out,
  input wire match_irq_out,
  input wire waveform_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // completed control write carrying a force strobe in a non-pwm mode
  wire force_wr = psel_in && penable_in && pready_out && pwrite_in && paddr_in == 8'h00 &&
    pwdata_in[7] && !pwdata_in[0];
  ////////////////////////////////////////////////////////////////////////////
  property p_ready_after_setup;
    psel_in && !penable_in |=> pready_out;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
  property p_ready_single;
    pready_out |=> !pready_out;
  endproperty
  a_ready_single: assert property (p_ready_single) else $error("ready held too long");
  property p_err_with_ready;
    pslverr_out |-> pready_out;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
  property p_read_upper;
    pready_out && !pwrite_in |-> prdata_out[31:8] == 24'h000000;
  endproperty
  a_read_upper: assert property (p_read_upper) else $error("upper read bits set");
  property p_err_data;
    pslverr_out && !pwrite_in |-> prdata_out == 32'h00000000;
  endproperty
  a_err_data: assert property (p_err_data) else $error("unmapped read not zero");
  // reset is not a disable here: this one checks the reset state itself
  property p_reset_state;
    disable iff (1'b0) !rst_n_in |=> !pready_out && !waveform_out && !match_irq_out &&
      !overflow_irq_out && crystal_out;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad reset state");
  property p_force_set;
    force_wr && pwdata_in[5:4] == 2'h3 |-> ##[1:2] waveform_out;
  endproperty
  a_force_set: assert property (p_force_set) else $error("forced set missed");
  property p_force_clear;
    force_wr && pwdata_in[5:4] == 2'h2 |-> ##[1:2] !waveform_out;
  endproperty
  a_force_clear: assert property (p_force_clear) else $error("forced clear missed");
  // acks are only pulsed by the bench while the timer is stopped
  property p_match_ack;
    match_ack_in |-> ##2 !match_irq_out;
  endproperty
  a_match_ack: assert property (p_match_ack) else $error("match irq after ack");
  property p_ovf_ack;
    overflow_ack_in |-> ##2 !overflow_irq_out;
  endproperty
  a_ovf_ack: assert property (p_ovf_ack) else $error("overflow irq after ack");
  property p_xtal_inv;
    $stable(crystal_in) [*6] |-> crystal_out != crystal_in;
  endproperty
  a_xtal_inv: assert property (p_xtal_inv) else $error("crystal out not inverse");
endmodule
bind t8sc_timer t8sc_props u_t8sc_props (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .crystal_in(crystal_in), .crystal_out(crystal_out),
  .overflow_ack_in(overflow_ack_in), .match_ack_in(match_ack_in),
  .overflow_irq_out(overflow_irq_out), .match_irq_out(match_irq_out),
  .waveform_out(waveform_out));

//--- verif/t8sc_xtal_model.sv
`timescale 1ns/1ps
// crystal oscillator beside the crystal pins
module t8sc_xtal_model (
  input wire run_in,
  output reg xtal_out,
  output reg [7:0] rises_out
);
  initial begin
    xtal_out = 1'b0;
    rises_out = 8'h00;
  end
  // phase unrelated to the core clock; stands still while not running
  always begin
    #173;
    if (run_in) begin
      xtal_out = ~xtal_out;
      if (xtal_out)
        rises_out = rises_out + 8'h01; // counted so the bench knows the expected count
    end
  end
endmodule

//--- verif/tb_top.sv
`timescale 1ns/1ps
`include "t8sc_regs.vh"
// apb master, read monitor and timer scenarios
module tb_top;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg psel = 1'b0;
  reg pen = 1'b0;
  reg pwr = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg oack = 1'b0;
  reg mack = 1'b0;
  reg xrun = 1'b0;
  wire [31:0] prdata;
  wire pready, perr, xin, xout, oirq, mirq, wave;
  wire [7:0] rises;
  integer errors = 0;
  integer total_checks = 0;
  integer seed = 94;
  integer i;
  reg [32:0] expq [$]; // expected {error, data} of each read, oldest first
  reg [31:0] r;
  reg [7:0] a;
  reg [7:0] acts = 8'h1b; // force actions set, clear, toggle, none
  reg [3:0] wexp = 4'b1101; // output state after each of them
  always #20 clk = ~clk;
  t8sc_timer u_t8sc_timer (.core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr), .crystal_in(xin),
    .crystal_out(xout), .overflow_ack_in(oack), .match_ack_in(mack),
    .overflow_irq_out(oirq), .match_irq_out(mirq), .waveform_out(wave));
  t8sc_xtal_model u_t8sc_xtal_model (.run_in(xrun), .xtal_out(xin), .rises_out(rises));
  ////////////////////////////////////////////////////////////////////////////
  task check(input [8*6-1:0] name, input [32:0] seen, input [32:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("BAD %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // one apb transfer; holds everything until ready, then idles a cycle
  // no wait limit of its own: only the watchdog ends a hung access
  task apb(input w, input [7:0] ad, input [31:0] d);
    begin
      psel <= 1'b1;
      pwr <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
        @(posedge clk);
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
    end
  endtask
  task wr(input [7:0] ad, input [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task rd(input [7:0] ad, input [32:0] exp);
    begin
      expq.push_back(exp);
      apb(1'b0, ad, 32'h0);
    end
  endtask
  // monitor: each read answer meets the oldest expectation
  always @(posedge clk) begin
    if (pready === 1'b1 && pwr === 1'b0 && expq.size() > 0)
      check("read", {perr, prdata}, expq.pop_front());
  end
  initial begin
    #400000;
    errors = errors + 1;
    tally_and_finish;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(4);
    rst_n <= 1'b1;
    tick(1);
    for (a = 8'h00; a < 8'h18; a = a + 8'h04)
      rd(a, 33'h0);
    rd(`T8SC_STAT_OFF, 33'h2);
    wr(8'h1c, 32'hff);
    rd(8'h1c, {1'b1, 32'h0}); // unmapped place refused
    // random bytes with junk above them, timer stopped
    for (i = 0; i < 4; i = i + 1) begin
      r = $random(seed);
      wr(`T8SC_CNT_OFF, r);
      wr(`T8SC_CMP_OFF, ~r);
      tick(3);
      rd(`T8SC_CNT_OFF, {25'h0, r[7:0]});
      rd(`T8SC_CMP_OFF, {25'h0, ~r[7:0]});
    end
    wr(`T8SC_CNT_OFF, 32'hff);
    rd(`T8SC_STAT_OFF, 33'h4);
    // normal mode wrap with only overflow unmasked
    wr(`T8SC_CMP_OFF, 32'h0);
    wr(`T8SC_MASK_OFF, 32'h1);
    wr(`T8SC_CNT_OFF, 32'hf0);
    wr(`T8SC_CLK_OFF, 32'h1);
    i = 0;
    while (oirq !== 1'b1 && i < 60) begin
      i = i + 1;
      tick(1);
    end
    check("ovfirq", {32'h0, oirq}, 33'h1);
    check("matirq", {32'h0, mirq}, 33'h0);
    wr(`T8SC_CLK_OFF, 32'h0);
    rd(`T8SC_FLAG_OFF, 33'h3);
    wr(`T8SC_MASK_OFF, 32'h3);
    tick(2);
    check("matirq", {32'h0, mirq}, 33'h1);
    wr(`T8SC_FLAG_OFF, 32'h1);
    rd(`T8SC_FLAG_OFF, 33'h2);
    mack <= 1'b1;
    oack <= 1'b1;
    tick(1);
    mack <= 1'b0;
    oack <= 1'b0;
    tick(1);
    rd(`T8SC_FLAG_OFF, 33'h0);
    // clear on match keeps the count below max: no overflow
    wr(`T8SC_CTRL_OFF, 32'h2);
    wr(`T8SC_CMP_OFF, 32'h05);
    wr(`T8SC_CNT_OFF, 32'h0);
    wr(`T8SC_CLK_OFF, 32'h1);
    tick(300);
    wr(`T8SC_CLK_OFF, 32'h0);
    rd(`T8SC_FLAG_OFF, 33'h2);
    // fast pwm: new compare waits in the buffer, so 0x30 is passed unmatched
    wr(`T8SC_FLAG_OFF, 32'h3);
    wr(`T8SC_CTRL_OFF, 32'h3);
    wr(`T8SC_CNT_OFF, 32'h20);
    wr(`T8SC_CMP_OFF, 32'h30);
    wr(`T8SC_CLK_OFF, 32'h1);
    tick(20);
    wr(`T8SC_CLK_OFF, 32'h0);
    rd(`T8SC_FLAG_OFF, 33'h0);
    // forced matches in normal mode move the output only
    wr(`T8SC_CTRL_OFF, 32'h0);
    wr(`T8SC_CNT_OFF, 32'h40);
    for (i = 0; i < 4; i = i + 1) begin
      wr(`T8SC_CTRL_OFF, {24'h0, 2'b10, acts[2*i+:2], 4'h0});
      tick(2);
      check("wave", {32'h0, wave}, {32'h0, wexp[i]});
    end
    rd(`T8SC_FLAG_OFF, 33'h0);
    rd(`T8SC_CNT_OFF, 33'h40);
    wr(`T8SC_CTRL_OFF, 32'h93);
    tick(2);
    check("wave", {32'h0, wave}, 33'h1); // ignored in pwm
    // counter write blocks the match on the first tick after it
    wr(`T8SC_CTRL_OFF, 32'h0);
    wr(`T8SC_CMP_OFF, 32'h10);
    wr(`T8SC_CNT_OFF, 32'h10);
    wr(`T8SC_CLK_OFF, 32'h1);
    wr(`T8SC_CLK_OFF, 32'h0);
    rd(`T8SC_FLAG_OFF, 33'h0);
    // crystal clocking: no count while the crystal stands still
    wr(`T8SC_CNT_OFF, 32'h0);
    wr(`T8SC_CLK_OFF, 32'h9);
    tick(30);
    rd(`T8SC_CNT_OFF, 33'h0);
    xrun <= 1'b1;
    tick(200);
    xrun <= 1'b0;
    tick(10);
    wr(`T8SC_CLK_OFF, 32'h0);
    rd(`T8SC_CNT_OFF, {25'h0, rises});
    // real match in normal mode clears the output, which stood high
    wr(`T8SC_FLAG_OFF, 32'h3);
    wr(`T8SC_CTRL_OFF, 32'h20);
    wr(`T8SC_CNT_OFF, 32'h0);
    wr(`T8SC_CLK_OFF, 32'h1);
    tick(30);
    wr(`T8SC_CLK_OFF, 32'h0);
    check("wave", {32'h0, wave}, 33'h0);
    rd(`T8SC_FLAG_OFF, 33'h2);
    // dual slope: three ticks from 0xfd turn at max, back down to 0xfe
    wr(`T8SC_CTRL_OFF, 32'h1);
    wr(`T8SC_CNT_OFF, 32'hfd);
    wr(`T8SC_CLK_OFF, 32'h1);
    wr(`T8SC_CLK_OFF, 32'h0);
    rd(`T8SC_STAT_OFF, 33'h8);
    rd(`T8SC_CNT_OFF, 33'hfe);
    // still counting down: overflow comes at bottom, then up again
    wr(`T8SC_FLAG_OFF, 32'h3);
    wr(`T8SC_CNT_OFF, 32'h02);
    wr(`T8SC_CLK_OFF, 32'h1);
    wr(`T8SC_CLK_OFF, 32'h0);
    rd(`T8SC_CNT_OFF, 33'h01);
    rd(`T8SC_FLAG_OFF, 33'h1);
    // divide by eight: 61 enabled edges hold seven ticks, three edges of margin
    wr(`T8SC_CTRL_OFF, 32'h0);
    wr(`T8SC_CNT_OFF, 32'h0);
    wr(`T8SC_CLK_OFF, 32'h2);
    tick(58);
    wr(`T8SC_CLK_OFF, 32'h0);
    rd(`T8SC_CNT_OFF, 33'h07);
    // every noted read answer must have been met
    check("left", {1'b0, expq.size()}, 33'h0);
    tally_and_finish;
  end
endmodule
